// File: tlie_top.sv
// top: axi4-lite slave holding the top-level irq enable and pending state
//
// Behaviour
// R1: writing 1 to an enable-set bit enables that source, others unchanged
// R2: zeros written to enable-set leave enables unchanged
// R3: writing 1 to an enable-clear bit disables that source, same mapping
// R4: zeros written to enable-clear have no effect
// R5: writing 1 to a pending-set bit forces that source pending
// R6: zeros written to pending-set leave pending state unchanged
// R7: bit 16 debug, 15..12 ext lines d..a, 11 converter, 10..8 radio
// R8: bit 7 crypto, 6..5 serial 2/1, 4 sleep, 3 baseband, 2 mgmt, 1..0 timers
// R9: after reset every enable and pending bit is zero
// R10: writing 1 to a pending-clear bit removes pending, zeros ignored
// R11: bits 31..17 read zero and ignore writes
// R12: enable registers read enable vector; pending registers read pending
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module tlie_top (
	input  wire logic        core_clk,
	input  wire logic        srst,
	// axi4-lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// interrupt sources and core exception logic
	input  wire logic [16:0] src_req,
	input  wire logic [16:0] src_ack,
	output logic [16:0]      irq_enable,
	output logic [16:0]      irq_pending,
	output logic [16:0]      irq_to_core
);
	// write channel holding registers
	logic        aw_full_q;
	logic        aw_full_d;
	logic [31:0] aw_addr_q;
	logic [31:0] aw_addr_d;
	logic        w_full_q;
	logic        w_full_d;
	logic [31:0] w_data_q;
	logic [31:0] w_data_d;
	logic [3:0]  w_strb_q;
	logic [3:0]  w_strb_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	// read channel registers
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	// state vectors from the core
	logic [16:0] enable_vec;
	logic [16:0] pending_vec;

	tlie_wr_if wr_bus ();

	// handshake readiness: one write and one read in flight
	assign s_axi_awready = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready  = ~w_full_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;

	// merged address and data of the write being committed
	wire        aw_have  = aw_full_q | aw_take;
	wire        w_have   = w_full_q | w_take;
	wire [31:0] cur_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
	wire [31:0] cur_data = w_full_q ? w_data_q : s_axi_wdata;
	wire [3:0]  cur_strb = w_full_q ? w_strb_q : s_axi_wstrb;
	wire        wr_fire  = aw_have & w_have & ~bvalid_q;

	// write address decode
	wire wa_es = cur_addr == tlie_pkg::ENABLE_SET_ADDR;
	wire wa_ec = cur_addr == tlie_pkg::ENABLE_CLEAR_ADDR;
	wire wa_ps = cur_addr == tlie_pkg::PENDING_SET_ADDR;
	wire wa_pc = cur_addr == tlie_pkg::PENDING_CLEAR_ADDR;
	wire wa_hit = wa_es | wa_ec | wa_ps | wa_pc;

	// byte lanes gate the 17 implemented bits; upper bits dropped
	wire [16:0] lane_mask = {cur_strb[2], {8{cur_strb[1]}},
		{8{cur_strb[0]}}};
	assign wr_bus.data = cur_data[16:0] & lane_mask; // R11
	assign wr_bus.sel  = {4{wr_fire}} & {wa_pc, wa_ps, wa_ec, wa_es};

	// write channel next state
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d  = w_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (aw_take) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (w_take) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wa_hit ? tlie_pkg::RESP_OKAY : tlie_pkg::RESP_SLVERR;
		end else if (bvalid_q & s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// read decode: both enable registers show the enable vector
	wire ra_en   = (s_axi_araddr == tlie_pkg::ENABLE_SET_ADDR)
		| (s_axi_araddr == tlie_pkg::ENABLE_CLEAR_ADDR);
	wire ra_pend = (s_axi_araddr == tlie_pkg::PENDING_SET_ADDR)
		| (s_axi_araddr == tlie_pkg::PENDING_CLEAR_ADDR);
	wire [16:0] rd_vec = ra_en ? enable_vec
		: (ra_pend ? pending_vec : 17'h00000); // R12

	// read channel next state
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (ar_take) begin
			rvalid_d = 1'b1;
			rdata_d  = {15'h0000, rd_vec}; // R11
			rresp_d  = (ra_en | ra_pend) ? tlie_pkg::RESP_OKAY
				: tlie_pkg::RESP_SLVERR;
		end else if (rvalid_q & s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// bus slave registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 32'h00000000;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= 2'h0;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q  <= w_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// enable and pending state; bit map fixed by the package positions
	tlie_state_core u_core (
		.core_clk  (core_clk),
		.srst      (srst),
		.wr        (wr_bus),
		.src_req   (src_req),
		.src_ack   (src_ack),
		.enable_q  (enable_vec),
		.pending_q (pending_vec)
	); // R7 R8

	// outputs to the bus and the core
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;
	assign irq_enable   = enable_vec;
	assign irq_pending  = pending_vec;
	assign irq_to_core  = enable_vec & pending_vec;
endmodule

// File: tlie_pkg.sv
// package: register map, bit positions and constants of the irq enable block
package tlie_pkg;
	localparam int unsigned NUM_SRC = 17;
	localparam int unsigned ADDR_W  = 32;
	localparam int unsigned DATA_W  = 32;

	// register byte addresses
	localparam logic [31:0] ENABLE_SET_ADDR    = 32'hE000E100;
	localparam logic [31:0] ENABLE_CLEAR_ADDR  = 32'hE000E180;
	localparam logic [31:0] PENDING_SET_ADDR   = 32'hE000E200;
	localparam logic [31:0] PENDING_CLEAR_ADDR = 32'hE000E280;

	// reset values
	localparam logic [16:0] ENABLE_RESET  = 17'h00000;
	localparam logic [16:0] PENDING_RESET = 17'h00000;

	// source bit positions
	localparam int unsigned GENERAL_TIMER_ONE_BIT = 0;
	localparam int unsigned GENERAL_TIMER_TWO_BIT = 1;
	localparam int unsigned MANAGEMENT_SOURCE_BIT = 2;
	localparam int unsigned BASEBAND_SOURCE_BIT   = 3;
	localparam int unsigned SLEEP_TIMER_BIT       = 4;
	localparam int unsigned SERIAL_CTRL_ONE_BIT   = 5;
	localparam int unsigned SERIAL_CTRL_TWO_BIT   = 6;
	localparam int unsigned CRYPTO_SOURCE_BIT     = 7;
	localparam int unsigned RADIO_TIMER_BIT       = 8;
	localparam int unsigned RADIO_TRANSMIT_BIT    = 9;
	localparam int unsigned RADIO_RECEIVE_BIT     = 10;
	localparam int unsigned CONVERTER_SOURCE_BIT  = 11;
	localparam int unsigned EXT_LINE_A_BIT        = 12;
	localparam int unsigned EXT_LINE_B_BIT        = 13;
	localparam int unsigned EXT_LINE_C_BIT        = 14;
	localparam int unsigned EXT_LINE_D_BIT        = 15;
	localparam int unsigned DEBUG_SOURCE_BIT      = 16;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// decoded register strobe lanes
	localparam int unsigned SEL_ENA_SET   = 0;
	localparam int unsigned SEL_ENA_CLR   = 1;
	localparam int unsigned SEL_PEND_SET  = 2;
	localparam int unsigned SEL_PEND_CLR  = 3;
	localparam int unsigned NUM_SEL       = 4;
endpackage

// File: tlie_wr_if.sv
// interface: register write strobes from the bus slave to the state core
`timescale 1ns/1ps
interface tlie_wr_if;
	logic [3:0]  sel;   // one-hot register selected by a taken write
	logic [16:0] data;  // implemented write data bits
	modport bus  (output sel, output data);
	modport core (input sel, input data);
endinterface

// File: tlie_state_core.sv
// module: enable and pending state flops with set/clear per source
`timescale 1ns/1ps
module tlie_state_core (
	input  wire logic        core_clk,
	input  wire logic        srst,
	tlie_wr_if.core          wr,
	input  wire logic [16:0] src_req,
	input  wire logic [16:0] src_ack,
	output logic      [16:0] enable_q,
	output logic      [16:0] pending_q
);
	genvar i;
	// per-source enable and pending bit, set winning over clear
	generate
		for (i = 0; i < tlie_pkg::NUM_SRC; i++) begin : g_src
			wire ena_set  = wr.sel[tlie_pkg::SEL_ENA_SET] & wr.data[i];
			wire ena_clr  = wr.sel[tlie_pkg::SEL_ENA_CLR] & wr.data[i];
			wire pend_set = (wr.sel[tlie_pkg::SEL_PEND_SET] & wr.data[i])
				| src_req[i];
			wire pend_clr = (wr.sel[tlie_pkg::SEL_PEND_CLR] & wr.data[i])
				| src_ack[i];
			wire ena_d  = ena_set | (enable_q[i] & ~ena_clr); // R1 R2 R3 R4
			wire pend_d = pend_set | (pending_q[i] & ~pend_clr); // R5 R6 R10
			always_ff @(posedge core_clk) begin
				if (srst) begin
					enable_q[i]  <= tlie_pkg::ENABLE_RESET[i];   // R9
					pending_q[i] <= tlie_pkg::PENDING_RESET[i];  // R9
				end else begin
					enable_q[i]  <= ena_d;
					pending_q[i] <= pend_d;
				end
			end
		end
	endgenerate
endmodule

// File: tlie_chk.sv
// checker: bus and state-update properties of the irq enable block
`timescale 1ns/1ps
module tlie_chk (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [16:0] src_req,
	input wire logic [16:0] irq_enable,
	input wire logic [16:0] irq_pending
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// address of a write taken on both channels, else zero
	wire logic        hs = s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready;
	wire logic [31:0] wa = hs ? s_axi_awaddr : 32'h0;
	wire logic [16:0] wd = s_axi_wdata[16:0];
	wire logic [16:0] wk = wd & ~src_req;
	a_reset_clear: assert property ($fell(srst) |->
		irq_enable == 17'h0 && irq_pending == 17'h0)
		else $error("state not zero after reset");
	a_ena_set: assert property (wa == tlie_pkg::ENABLE_SET_ADDR |=>
		irq_enable == ($past(irq_enable) | $past(wd)))
		else $error("enable set wrong");
	a_ena_clr: assert property (wa == tlie_pkg::ENABLE_CLEAR_ADDR |=>
		irq_enable == ($past(irq_enable) & ~$past(wd)))
		else $error("enable clear wrong");
	a_pend_set: assert property (wa == tlie_pkg::PENDING_SET_ADDR |=>
		(irq_pending & $past(wd)) == $past(wd))
		else $error("pending set missed");
	a_pend_clr: assert property (wa == tlie_pkg::PENDING_CLEAR_ADDR |=>
		(irq_pending & $past(wk)) == 17'h0)
		else $error("pending clear missed");
	a_src_pends: assert property (|src_req |=>
		(irq_pending & $past(src_req)) == $past(src_req))
		else $error("request not pending");
	a_high_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:17] == 15'h0) else $error("upper bits not zero");
	// a read of either enable register returns the enable vector at take
	a_rd_enable: assert property (s_axi_arvalid && s_axi_arready &&
		(s_axi_araddr == tlie_pkg::ENABLE_SET_ADDR ||
		s_axi_araddr == tlie_pkg::ENABLE_CLEAR_ADDR) |=>
		s_axi_rdata[16:0] == $past(irq_enable))
		else $error("enable read value wrong");
	// a read of pending-set returns the pending vector at take
	a_rd_pending: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == tlie_pkg::PENDING_SET_ADDR |=>
		s_axi_rdata[16:0] == $past(irq_pending))
		else $error("pending read value wrong");
	// read answer stands until the master takes it
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	c_clr: cover property (wa == tlie_pkg::PENDING_CLEAR_ADDR);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_req: cover property (|src_req);
endmodule
bind tlie_top tlie_chk u_chk (.core_clk, .srst, .s_axi_awaddr, .s_axi_wdata,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_arready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .src_req,
	.irq_enable, .irq_pending);

// File: tlie_src_model.sv
// partner: peripheral requests and core acknowledges
`timescale 1ns/1ps
module tlie_src_model (
	input  wire logic        core_clk,
	input  wire logic        act,
	input  wire logic [16:0] irq_to_core,
	output logic      [16:0] src_req,
	output logic      [16:0] src_ack
);
	integer seed = 32'hf080a10a;
	initial begin
		src_req = 17'h0;
		src_ack = 17'h0;
	end
	// sparse requests; the core acks only lines it sees
	always @(posedge core_clk) begin
		src_req <= act ? 17'($random(seed) & $random(seed)) : 17'h0;
		src_ack <= act ? irq_to_core & 17'($random(seed)) : 17'h0;
	end
endmodule

// File: top_level_irq_enable_pend_test.sv
// testbench: bus master, reference model and checks of the irq block
`timescale 1ns/1ps
module top_level_irq_enable_pend_test;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        act = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, exp_rd;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [16:0] src_req, src_ack, irq_enable, irq_pending, irq_to_core;
	logic [16:0] m_en, m_pd;
	integer      n_errors = 0, check_count = 0, seed = 32'hf080a10a, i;
	logic [31:0] regs [5] = '{tlie_pkg::ENABLE_SET_ADDR,
		tlie_pkg::ENABLE_CLEAR_ADDR, tlie_pkg::PENDING_SET_ADDR,
		tlie_pkg::PENDING_CLEAR_ADDR, 32'hE000E104};
	always #12.5 core_clk = ~core_clk;
	tlie_top dut_u (.core_clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .src_req, .src_ack, .irq_enable, .irq_pending,
		.irq_to_core);
	tlie_src_model u_src (.core_clk, .act, .irq_to_core, .src_req, .src_ack);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] rmap(input logic [31:0] a);
		if (a == regs[0] || a == regs[1])
			return {15'h0, m_en};
		if (a == regs[2] || a == regs[3])
			return {15'h0, m_pd};
		return 32'h0;
	endfunction
	function automatic logic [1:0] rsp(input logic [31:0] a);
		return a == regs[4] ? tlie_pkg::RESP_SLVERR : tlie_pkg::RESP_OKAY;
	endfunction
	// reference model: compare every cycle out of reset, then advance
	always @(posedge core_clk) begin
		if (srst) begin
			m_en = 17'h0;
			m_pd = 17'h0;
		end else begin
			chk(irq_enable, m_en);
			chk(irq_pending, m_pd);
			chk(irq_to_core, m_en & m_pd);
			if (s_axi_arvalid && s_axi_arready)
				exp_rd = rmap(s_axi_araddr);
			m_pd = m_pd & ~src_ack;
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
				case (s_axi_awaddr)
					regs[0]: m_en = m_en | s_axi_wdata[16:0];
					regs[1]: m_en = m_en & ~s_axi_wdata[16:0];
					regs[2]: m_pd = m_pd | s_axi_wdata[16:0];
					regs[3]: m_pd = m_pd & ~s_axi_wdata[16:0];
					default: m_pd = m_pd;
				endcase
			m_pd = m_pd | src_req;
		end
	end
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw, w;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge core_clk);
			aw = aw && s_axi_awready !== 1'b1;
			w = w && s_axi_wready !== 1'b1;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, rsp(a));
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, exp_rd);
		chk(s_axi_rresp, rsp(a));
		s_axi_rready <= 1'b0;
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// walking bits, then random traffic with live sources
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		for (i = 0; i < 5; i++)
			rd(regs[i]);
		for (i = 0; i < 17; i++) begin
			wr(regs[0], 32'h1 << i);
			wr(regs[2], 32'h1 << i);
			rd(regs[i % 4]);
		end
		act <= 1'b1;
		repeat (80) begin
			wr(regs[$unsigned($random(seed)) % 5], $random(seed));
			rd(regs[$unsigned($random(seed)) % 5]);
		end
		test_done;
	end
	// watchdog: the sequence needs well under 5000 cycles
	initial begin
		#(25 * 20000);
		n_errors++;
		test_done;
	end
endmodule
